/* File: include/iatr_pkg.sv */
// Purpose: shared constants for the input alarm threshold register block
// Assumes: 32-bit axi4-lite register bus, byte addresses as printed
// Notes:   field layouts, offsets and reset values live here only
`default_nettype none
package iatr_pkg;
  // ****************************************
  // bus
  // ****************************************
  localparam int          AXI_AW         = 8;
  localparam int          AXI_DW         = 32;
  localparam logic [1:0]  RESP_OKAY      = 2'h0;
  localparam logic [1:0]  RESP_SLVERR    = 2'h2;
  // ****************************************
  // register offsets
  // ****************************************
  localparam logic [7:0]  OFS_UPPER      = 8'h24;
  localparam logic [7:0]  OFS_LOWER      = 8'h28;
  localparam logic [7:0]  OFS_FLAGS      = 8'h2C;
  localparam logic [7:0]  OFS_IRQ_MASK   = 8'h30;
  // ****************************************
  // fields
  // ****************************************
  localparam int          LIM_W          = 16;
  localparam int          CMP_LSB        = 2;
  localparam int          HYST_MSB       = 31;
  localparam int          HYST_LSB       = 28;
  localparam int          HYST_W         = 4;
  localparam int          BYTE_HYST      = 3;
  localparam logic [15:0] UPPER_RESET    = 16'hFFFF;
  localparam logic [15:0] LOWER_RESET    = 16'h0000;
  localparam logic [3:0]  HYST_RESET     = 4'h0;
  // flag register layout
  localparam int          FLG_SUMMARY    = 0;
  localparam int          FLG_HIGH       = 1;
  localparam int          FLG_LOW        = 2;
  localparam int          FLG_W          = 3;
  localparam int          ACT_HIGH       = 8;
  localparam int          ACT_LOW        = 9;
endpackage : iatr_pkg
`default_nettype wire

/* File: include/iatr_cmp_if.sv */
// Purpose: carries limits and result between register file and comparator
// Assumes: single clock domain
// Notes:   none
`default_nettype none
interface iatr_cmp_if;
  logic [15:0] upper_limit;
  logic [15:0] lower_limit;
  logic [3:0]  hysteresis;
  logic        sample_valid;
  logic [15:0] sample;
  logic        high_active;
  logic        low_active;
  modport regs (output upper_limit, output lower_limit, output hysteresis,
                output sample_valid, output sample, input high_active, input low_active);
  modport cmp  (input upper_limit, input lower_limit, input hysteresis,
                input sample_valid, input sample, output high_active, output low_active);
endinterface : iatr_cmp_if
`default_nettype wire

/* File: hw/iatr_compare.sv */
// Purpose: window comparator with hysteresis on conversion results
// Assumes: results are left aligned 14-bit codes
// Notes:   states update only on a valid sample
`default_nettype none
module iatr_compare
  import iatr_pkg::*;
(
  // clock and reset
  input  wire logic clock_i,
  input  wire logic rst_i,
  // link to register file
  iatr_cmp_if.cmp   cmp
);
  import iatr_pkg::*;
  logic [13:0] res;
  logic [13:0] hi_th;
  logic [13:0] lo_th;
  logic [14:0] hi_rel;
  logic [14:0] lo_rel;
  logic        high_q;
  logic        low_q;

  assign res   = cmp.sample[LIM_W-1:CMP_LSB];
  assign hi_th = cmp.upper_limit[LIM_W-1:CMP_LSB];
  assign lo_th = cmp.lower_limit[LIM_W-1:CMP_LSB];
  // release points widened one bit so the low one cannot wrap and a wrapped high one sets bit 14
  assign hi_rel = {1'b0, hi_th} - {11'h000, cmp.hysteresis};
  assign lo_rel = {1'b0, lo_th} + {11'h000, cmp.hysteresis};

  // ****************************************
  // high side
  // ****************************************
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      high_q <= 1'b0;
    end else if (cmp.sample_valid) begin
      if (res > hi_th) begin
        high_q <= 1'b1;
      end else if ({1'b0, res} < hi_rel || hi_rel[14]) begin
        high_q <= hi_rel[14] ? high_q : 1'b0;
      end
    end
  end

  // ****************************************
  // low side
  // ****************************************
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      low_q <= 1'b0;
    end else if (cmp.sample_valid) begin
      if (res < lo_th) begin
        low_q <= 1'b1;
      end else if ({1'b0, res} > lo_rel) begin
        low_q <= 1'b0;
      end
    end
  end

  assign cmp.high_active = high_q;
  assign cmp.low_active  = low_q;
endmodule : iatr_compare
`default_nettype wire

/* File: hw/iatr_regs.sv */
// Purpose: input alarm threshold and hysteresis registers with alarm flags
// Assumes: axi4-lite slave, single clock, synchronous active-high reset
// Notes:   upper limit at 24h, lower limit at 28h, byte lanes by wstrb
`default_nettype none
module iatr_regs
  import iatr_pkg::*;
(
  // clock and reset
  input  wire logic                clock_i,
  input  wire logic                rst_i,
  // conversion results
  input  wire logic                sample_valid_i,
  input  wire logic [15:0]         sample_i,
  // axi4-lite write address
  input  wire logic                s_axi_awvalid,
  output logic                     s_axi_awready,
  input  wire logic [AXI_AW-1:0]   s_axi_awaddr,
  // axi4-lite write data
  input  wire logic                s_axi_wvalid,
  output logic                     s_axi_wready,
  input  wire logic [AXI_DW-1:0]   s_axi_wdata,
  input  wire logic [3:0]          s_axi_wstrb,
  // axi4-lite write response
  output logic                     s_axi_bvalid,
  input  wire logic                s_axi_bready,
  output logic [1:0]               s_axi_bresp,
  // axi4-lite read address
  input  wire logic                s_axi_arvalid,
  output logic                     s_axi_arready,
  input  wire logic [AXI_AW-1:0]   s_axi_araddr,
  // axi4-lite read data
  output logic                     s_axi_rvalid,
  input  wire logic                s_axi_rready,
  output logic [AXI_DW-1:0]        s_axi_rdata,
  output logic [1:0]               s_axi_rresp,
  // alarm outputs
  output logic                     alarm_high_o,
  output logic                     alarm_low_o,
  output logic                     irq_o
);
  import iatr_pkg::*;

  // ****************************************
  // storage
  // ****************************************
  logic [LIM_W-1:0]   upper_limit;
  logic [7:0]         hyst_byte;
  logic [LIM_W-1:0]   lower_limit;
  logic [FLG_W-1:0]   tripped;
  logic [FLG_W-1:0]   irq_mask;
  logic [AXI_AW-1:0]  aw_addr;
  logic               aw_held;
  logic [AXI_DW-1:0]  w_data;
  logic [3:0]         w_strb;
  logic               w_held;
  logic               wr_fire;
  logic               wr_hit;
  logic [AXI_DW-1:0]  next_rdata;
  logic               rd_hit;
  logic               summary_alarm_bit;
  logic               high_prev;
  logic               low_prev;
  logic               high_rise;
  logic               low_rise;
  logic [FLG_W-1:0]   set_ev;
  logic [FLG_W-1:0]   clr_ev;

  iatr_cmp_if cmp_bus ();

  // ****************************************
  // write channel capture
  // ****************************************
  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready  = !w_held && !s_axi_bvalid;
  assign wr_fire       = aw_held && w_held && !s_axi_bvalid;

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      aw_held <= 1'b0;
      aw_addr <= '0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_held <= 1'b1;
      aw_addr <= s_axi_awaddr;
    end else if (wr_fire) begin
      aw_held <= 1'b0;
    end
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      w_held <= 1'b0;
      w_data <= '0;
      w_strb <= '0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_held <= 1'b1;
      w_data <= s_axi_wdata;
      w_strb <= s_axi_wstrb;
    end else if (wr_fire) begin
      w_held <= 1'b0;
    end
  end

  always_comb begin
    unique case (aw_addr)
      OFS_UPPER, OFS_LOWER, OFS_FLAGS, OFS_IRQ_MASK: wr_hit = 1'b1;
      default:                                       wr_hit = 1'b0;
    endcase
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // ****************************************
  // threshold and irq mask registers
  // ****************************************
  // byte lanes map to ascending byte addresses within each word
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      upper_limit <= UPPER_RESET;
      hyst_byte   <= {HYST_RESET, 4'h0};
    end else if (wr_fire && aw_addr == OFS_UPPER) begin
      if (w_strb[0]) upper_limit[7:0]  <= w_data[7:0];
      if (w_strb[1]) upper_limit[15:8] <= w_data[15:8];
      // lane 2 has no storage, bits 23-16 stay zero
      if (w_strb[BYTE_HYST]) hyst_byte <= w_data[31:24];
    end
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      lower_limit <= LOWER_RESET;
    end else if (wr_fire && aw_addr == OFS_LOWER) begin
      if (w_strb[0]) lower_limit[7:0]  <= w_data[7:0];
      if (w_strb[1]) lower_limit[15:8] <= w_data[15:8];
      // lanes 2 and 3 have no storage
    end
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      irq_mask <= '0;
    end else if (wr_fire && aw_addr == OFS_IRQ_MASK && w_strb[0]) begin
      irq_mask <= w_data[FLG_W-1:0];
    end
  end

  // ****************************************
  // comparator
  // ****************************************
  // bit offset of the hysteresis byte within the upper-limit word
  localparam int HYST_OFS = BYTE_HYST * 8;
  // low hysteresis nibble is stored and read back but never used
  assign cmp_bus.upper_limit  = upper_limit;
  assign cmp_bus.hysteresis   = hyst_byte[HYST_MSB-HYST_OFS:HYST_LSB-HYST_OFS];
  assign cmp_bus.lower_limit  = lower_limit;
  assign cmp_bus.sample_valid = sample_valid_i;
  assign cmp_bus.sample       = sample_i;

  iatr_compare u_compare (
    .clock_i (clock_i),
    .rst_i   (rst_i),
    .cmp     (cmp_bus)
  );

  // ****************************************
  // tripped flags and interrupt
  // ****************************************
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      high_prev <= 1'b0;
      low_prev  <= 1'b0;
    end else begin
      high_prev <= cmp_bus.high_active;
      low_prev  <= cmp_bus.low_active;
    end
  end

  assign high_rise = cmp_bus.high_active && !high_prev;
  assign low_rise  = cmp_bus.low_active && !low_prev;
  assign summary_alarm_bit = tripped[FLG_HIGH] | tripped[FLG_LOW];

  always_comb begin
    set_ev            = '0;
    set_ev[FLG_HIGH]  = high_rise;
    set_ev[FLG_LOW]   = low_rise;
    clr_ev            = '0;
    if (wr_fire && aw_addr == OFS_FLAGS && w_strb[0]) begin
      clr_ev = w_data[FLG_W-1:0];
    end
    clr_ev[FLG_SUMMARY] = 1'b0;
  end

  // set wins over a same-cycle write-one clear
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      tripped <= '0;
    end else begin
      tripped <= (tripped & ~clr_ev) | set_ev;
    end
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      irq_o        <= 1'b0;
      alarm_high_o <= 1'b0;
      alarm_low_o  <= 1'b0;
    end else begin
      irq_o        <= |({tripped[FLG_W-1:1], summary_alarm_bit} & irq_mask);
      alarm_high_o <= cmp_bus.high_active;
      alarm_low_o  <= cmp_bus.low_active;
    end
  end

  // ****************************************
  // read channel
  // ****************************************
  assign s_axi_arready = !s_axi_rvalid;

  always_comb begin
    next_rdata = '0;
    rd_hit     = 1'b1;
    unique case (s_axi_araddr)
      OFS_UPPER: next_rdata = {hyst_byte, 8'h00, upper_limit};
      OFS_LOWER: next_rdata = {16'h0000, lower_limit};
      OFS_FLAGS: begin
        next_rdata[FLG_SUMMARY] = summary_alarm_bit;
        next_rdata[FLG_HIGH]    = tripped[FLG_HIGH];
        next_rdata[FLG_LOW]     = tripped[FLG_LOW];
        next_rdata[ACT_HIGH]    = cmp_bus.high_active;
        next_rdata[ACT_LOW]     = cmp_bus.low_active;
      end
      OFS_IRQ_MASK: next_rdata[FLG_W-1:0] = irq_mask;
      default: rd_hit = 1'b0;
    endcase
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= '0;
      s_axi_rresp  <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= next_rdata;
      s_axi_rresp  <= rd_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end
endmodule : iatr_regs
`default_nettype wire

/* File: dv/iatr_regs_props.sv */
// Purpose: port checks for the threshold registers
// Assumes: read answered one edge after accept
// Notes:   pristine means no write taken since reset
`default_nettype none
module iatr_regs_props
  import iatr_pkg::*;
(
  // clock, reset, inputs
  input wire logic                        clock_i,
  input wire logic                        rst_i,
  input wire logic                        sample_valid_i,
  input wire logic                        s_axi_awvalid,
  input wire logic                        s_axi_arvalid,
  input wire logic                        s_axi_rready,
  input wire logic [iatr_pkg::AXI_AW-1:0] s_axi_araddr,
  // outputs
  input wire logic                        s_axi_awready,
  input wire logic                        s_axi_arready,
  input wire logic                        s_axi_rvalid,
  input wire logic [iatr_pkg::AXI_DW-1:0] s_axi_rdata,
  input wire logic                        alarm_high_o,
  input wire logic                        alarm_low_o
);
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (rst_i);
  logic [7:0] rd_addr;
  logic       pristine;
  logic [2:0] since_smp;
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      pristine  <= 1'b1;
      since_smp <= 3'h7;
    end else begin
      if (s_axi_awvalid && s_axi_awready) pristine <= 1'b0;
      if (sample_valid_i) since_smp <= 3'h0;
      else if (since_smp != 3'h7) since_smp <= since_smp + 3'h1;
    end
  end
  // address of the read being answered
  always_ff @(posedge clock_i) begin
    if (s_axi_arvalid && s_axi_arready) rd_addr <= s_axi_araddr;
  end
  sequence s_rd_taken; s_axi_arvalid && s_axi_arready; endsequence
  sequence s_rd_at(logic [7:0] a); s_axi_rvalid && rd_addr == a; endsequence
  property p_rd_next; s_rd_taken |=> s_axi_rvalid; endproperty
  a_rd_next: assert property (p_rd_next) else $error("read late");
  property p_rd_busy; s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid; endproperty
  a_rd_busy: assert property (p_rd_busy) else $error("read data held after rready");
  property p_up_rsvd; s_rd_at(OFS_UPPER) |-> s_axi_rdata[23:16] == 8'h00; endproperty
  a_up_rsvd: assert property (p_up_rsvd) else $error("upper reserved byte");
  property p_lo_rsvd; s_rd_at(OFS_LOWER) |-> s_axi_rdata[31:16] == 16'h0000; endproperty
  a_lo_rsvd: assert property (p_lo_rsvd) else $error("lower reserved half");
  property p_up_reset; s_rd_at(OFS_UPPER) ##0 pristine |-> s_axi_rdata == 32'h0000FFFF; endproperty
  a_up_reset: assert property (p_up_reset) else $error("upper reset value");
  property p_lo_reset; s_rd_at(OFS_LOWER) ##0 pristine |-> s_axi_rdata == 32'h00000000; endproperty
  a_lo_reset: assert property (p_lo_reset) else $error("lower reset value");
  property p_summary; s_rd_at(OFS_FLAGS) |-> s_axi_rdata[0] == |s_axi_rdata[2:1]; endproperty
  a_summary: assert property (p_summary) else $error("summary bit");
  property p_quiet; pristine |-> !alarm_high_o && !alarm_low_o; endproperty
  a_quiet: assert property (p_quiet) else $error("alarm at reset limits");
  property p_after_smp; $changed(alarm_high_o) || $changed(alarm_low_o) |-> since_smp <= 3'h4; endproperty
  a_after_smp: assert property (p_after_smp) else $error("alarm moved without sample");
endmodule : iatr_regs_props
bind iatr_regs iatr_regs_props u_props (.clock_i, .rst_i, .sample_valid_i, .s_axi_awvalid, .s_axi_arvalid,
  .s_axi_rready, .s_axi_araddr, .s_axi_awready, .s_axi_arready, .s_axi_rvalid, .s_axi_rdata,
  .alarm_high_o, .alarm_low_o);
`default_nettype wire

/* File: dv/iatr_host.sv */
// Purpose: bus host model for the threshold registers
// Assumes: one write and one read at a time
// Notes:   released address and data lines show the inverted last value
`default_nettype none
module iatr_host
  import iatr_pkg::*;
(
  // clock
  input  wire logic              clock_i,
  // write channels
  output logic                   s_axi_awvalid,
  input  wire logic              s_axi_awready,
  output logic [AXI_AW-1:0]      s_axi_awaddr,
  output logic                   s_axi_wvalid,
  input  wire logic              s_axi_wready,
  output logic [AXI_DW-1:0]      s_axi_wdata,
  output logic [3:0]             s_axi_wstrb,
  input  wire logic              s_axi_bvalid,
  output logic                   s_axi_bready,
  input  wire logic [1:0]        s_axi_bresp,
  // read channels
  output logic                   s_axi_arvalid,
  input  wire logic              s_axi_arready,
  output logic [AXI_AW-1:0]      s_axi_araddr,
  input  wire logic              s_axi_rvalid,
  output logic                   s_axi_rready,
  input  wire logic [AXI_DW-1:0] s_axi_rdata,
  input  wire logic [1:0]        s_axi_rresp
);
  initial {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready,
           s_axi_awaddr, s_axi_wdata, s_axi_wstrb, s_axi_araddr} = '0;
  // response stays unknown on timeout so the caller sees a mismatch
  task automatic wr(input logic [7:0] a, input logic [31:0] v, input logic [3:0] s, output logic [1:0] r);
    int n;
    if (a == OFS_UPPER) v[27:24] = 4'h0;
    if (a inside {OFS_UPPER, OFS_LOWER}) v[1:0] = 2'h0;
    r = 'x;
    @(posedge clock_i);
    s_axi_awvalid <= 1'b1;
    s_axi_awaddr <= a;
    s_axi_wvalid <= 1'b1;
    s_axi_wdata <= v;
    s_axi_wstrb <= s;
    s_axi_bready <= 1'b1;
    for (n = 0; n < 64; n++) begin
      @(posedge clock_i);
      if (s_axi_awvalid && s_axi_awready) begin
        s_axi_awvalid <= 1'b0;
        s_axi_awaddr <= ~a;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        s_axi_wvalid <= 1'b0;
        s_axi_wdata <= ~v;
      end
      if (s_axi_bvalid) begin
        r = s_axi_bresp;
        break;
      end
    end
    s_axi_bready <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] r);
    int n;
    v = 'x;
    r = 'x;
    @(posedge clock_i);
    s_axi_arvalid <= 1'b1;
    s_axi_araddr <= a;
    s_axi_rready <= 1'b1;
    for (n = 0; n < 64; n++) begin
      @(posedge clock_i);
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arvalid <= 1'b0;
        s_axi_araddr <= ~a;
      end
      if (s_axi_rvalid) begin
        v = s_axi_rdata;
        r = s_axi_rresp;
        break;
      end
    end
    s_axi_rready <= 1'b0;
  endtask : rd
endmodule : iatr_host
`default_nettype wire

/* File: dv/iatr_regs_bench.sv */
// Purpose: register, alarm and irq scenarios
// Assumes: host model makes every access
// Notes:   expectations worked by hand
`default_nettype none
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin mismatches++; \
  $display("ERROR %s exp %h got %h", nm, e, g); end end
module iatr_regs_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import iatr_pkg::*;
  logic        clock_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        sample_valid_i = 1'b0;
  logic [15:0] sample_i = 16'h0000;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic        s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, alarm_high_o, alarm_low_o, irq_o;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, d;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp, r;
  int          mismatches = 0;
  int          n_checks = 0;
  always #2.5 clock_i = ~clock_i;
  iatr_regs dut (.clock_i, .rst_i, .sample_valid_i, .sample_i, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr,
    .s_axi_wvalid, .s_axi_wready, .s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp,
    .s_axi_arvalid, .s_axi_arready, .s_axi_araddr, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .s_axi_rresp,
    .alarm_high_o, .alarm_low_o, .irq_o);
  iatr_host host (.clock_i, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr, .s_axi_wvalid, .s_axi_wready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid, .s_axi_arready,
    .s_axi_araddr, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .s_axi_rresp);
  task automatic test_done;
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : test_done
  task automatic wchk(input logic [7:0] a, input logic [31:0] v, input logic [3:0] s, input logic [1:0] e);
    host.wr(a, v, s, r);
    `CHK("bresp", e, r)
  endtask : wchk
  task automatic rchk(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
    host.rd(a, d, r);
    `CHK("rresp", er, r)
    `CHK("rdata", e, d)
  endtask : rchk
  // one conversion result, then alarms after the pipeline settles
  task automatic smp(input logic [15:0] v, input logic eh, input logic el);
    @(posedge clock_i);
    sample_valid_i <= 1'b1;
    sample_i <= v;
    @(posedge clock_i);
    sample_valid_i <= 1'b0;
    sample_i <= ~v;
    repeat (4) @(posedge clock_i);
    `CHK("alarm_high", eh, alarm_high_o)
    `CHK("alarm_low", el, alarm_low_o)
  endtask : smp
  task automatic ichk(input logic e);
    repeat (3) @(posedge clock_i);
    `CHK("irq", e, irq_o)
  endtask : ichk
  // hang guard
  initial begin
    #100000;
    mismatches++;
    test_done();
  end
  initial begin
    repeat (12) @(posedge clock_i);
    rst_i <= 1'b0;
    rchk(OFS_UPPER, 32'h0000FFFF, RESP_OKAY);
    rchk(OFS_LOWER, 32'h00000000, RESP_OKAY);
    wchk(OFS_UPPER, 32'h45C38003, 4'hF, RESP_OKAY);
    rchk(OFS_UPPER, 32'h40008000, RESP_OKAY);
    wchk(OFS_LOWER, 32'hFFFF4000, 4'hF, RESP_OKAY);
    rchk(OFS_LOWER, 32'h00004000, RESP_OKAY);
    smp(16'h8003, 1'b0, 1'b0);
    smp(16'h8004, 1'b1, 1'b0);
    ichk(1'b0);
    rchk(OFS_FLAGS, 32'h00000103, RESP_OKAY);
    wchk(OFS_IRQ_MASK, 32'h00000002, 4'h1, RESP_OKAY);
    ichk(1'b1);
    smp(16'h7FF4, 1'b1, 1'b0);
    smp(16'h7FEC, 1'b0, 1'b0);
    wchk(OFS_FLAGS, 32'h00000002, 4'h1, RESP_OKAY);
    ichk(1'b0);
    rchk(OFS_FLAGS, 32'h00000000, RESP_OKAY);
    smp(16'h3FFC, 1'b0, 1'b1);
    rchk(OFS_FLAGS, 32'h00000205, RESP_OKAY);
    smp(16'h4010, 1'b0, 1'b1);
    smp(16'h4014, 1'b0, 1'b0);
    ichk(1'b0);
    wchk(OFS_IRQ_MASK, 32'h00000001, 4'h1, RESP_OKAY);
    ichk(1'b1);
    wchk(OFS_FLAGS, 32'h00000004, 4'h1, RESP_OKAY);
    ichk(1'b0);
    rchk(OFS_FLAGS, 32'h00000000, RESP_OKAY);
    wchk(OFS_UPPER, 32'h0000AB00, 4'h2, RESP_OKAY);
    wchk(OFS_UPPER, 32'h5FFFFFFF, 4'h8, RESP_OKAY);
    wchk(OFS_UPPER, 32'h00FF0000, 4'h4, RESP_OKAY);
    rchk(OFS_UPPER, 32'h5000AB00, RESP_OKAY);
    wchk(OFS_LOWER, 32'hFFFF0013, 4'hD, RESP_OKAY);
    rchk(OFS_LOWER, 32'h00004010, RESP_OKAY);
    wchk(8'h40, 32'h00000001, 4'hF, RESP_SLVERR);
    rchk(8'h40, 32'h00000000, RESP_SLVERR);
    test_done();
  end
endmodule : iatr_regs_bench
`default_nettype wire
